// File: src/qcmbd_pkg.sv
// package for the quad cpu memory and branch decoder
// assumes a single synchronous clock domain shared by all users
package qcmbd_pkg;

	// ---------------------------------------------------------------
	// instruction word layout
	// ---------------------------------------------------------------
	localparam int INSTR_W      = 24;
	localparam int OPC_MSB      = 23;
	localparam int OPC_LSB      = 17;
	localparam int OPC_W        = 7;
	localparam int SRC1_MSB     = 16;
	localparam int SRC1_LSB     = 11;
	localparam int SRC2_MSB     = 10;
	localparam int SRC2_LSB     = 5;
	localparam int DST_MSB      = 4;
	localparam int DST_LSB      = 0;
	localparam int IMM_MSB      = 16;
	localparam int IMM_LSB      = 5;
	localparam int REG_SEL_W    = 6;
	localparam int IMM_W        = 12;

	// ---------------------------------------------------------------
	// opcodes
	// ---------------------------------------------------------------
	localparam logic [6:0] OPC_BRANCH_ON_OVERFLOW_IMM   = 7'h1f;
	localparam logic [6:0] OPC_BRANCH_ON_OVERFLOW_REG   = 7'h20;
	localparam logic [6:0] OPC_BRANCH_NO_OVERFLOW_IMM   = 7'h21;
	localparam logic [6:0] OPC_BRANCH_NO_OVERFLOW_REG   = 7'h22;
	localparam logic [6:0] OPC_PRIVATE_IO_LOAD_REG_ADDR = 7'h3a;
	localparam logic [6:0] OPC_PRIVATE_IO_LOAD_IMM_ADDR = 7'h3b;
	localparam logic [6:0] OPC_PRIVATE_IO_STORE_REG_ADDR = 7'h3c;
	localparam logic [6:0] OPC_PRIVATE_IO_STORE_IMM_ADDR = 7'h3d;
	localparam logic [6:0] OPC_GLOBAL_IO_LOAD_REG_ADDR  = 7'h3e;
	localparam logic [6:0] OPC_GLOBAL_IO_LOAD_IMM_ADDR  = 7'h3f;
	localparam logic [6:0] OPC_GLOBAL_IO_STORE_REG_ADDR = 7'h40;
	localparam logic [6:0] OPC_GLOBAL_IO_STORE_IMM_ADDR = 7'h41;

	// ---------------------------------------------------------------
	// memory organisation
	// ---------------------------------------------------------------
	localparam int BLOCK_LINES  = 64;
	localparam int INSTR_DEPTH  = 2048;
	localparam int NUM_PORTS    = 4;

	// ---------------------------------------------------------------
	// decoded operation classes
	// ---------------------------------------------------------------
	typedef enum logic [2:0]
	{
		QCMBD_OP_NONE    = 3'h0,
		QCMBD_OP_LOAD_G  = 3'h1,
		QCMBD_OP_STORE_G = 3'h3,
		QCMBD_OP_LOAD_P  = 3'h2,
		QCMBD_OP_STORE_P = 3'h6,
		QCMBD_OP_BRANCH  = 3'h7
	} qcmbd_op_e;

	// port cycle phases of one memory block
	typedef enum logic [1:0]
	{
		QCMBD_PH_IDLE  = 2'h0,
		QCMBD_PH_DECODE = 2'h1,
		QCMBD_PH_SENSE = 2'h3,
		QCMBD_PH_WRITE = 2'h2
	} qcmbd_phase_e;

endpackage

// File: src/qcmbd_mem_block.sv
// one 64-line memory block with four independent ports
// assumes ports are driven synchronously to sys_clk_in
`timescale 1ns/1ps
module qcmbd_mem_block
	import qcmbd_pkg::*;
#(
	parameter int WIDTH = 24
)
(
	input  wire logic                   sys_clk_in,
	input  wire logic                   rst_in,
	input  wire logic                   clk_en_in,
	input  wire logic [NUM_PORTS-1:0]   rd_in,
	input  wire logic [NUM_PORTS-1:0]   wr_in,
	input  wire logic [NUM_PORTS*6-1:0] addr_in,
	input  wire logic [NUM_PORTS*WIDTH-1:0] wdata_in,
	output logic      [NUM_PORTS*WIDTH-1:0] rdata_out,
	output logic      [NUM_PORTS*2-1:0]     phase_out
);

	// refuse a line width that one block cannot hold
	if (WIDTH < 1 || WIDTH > 60)
	begin : g_bad_width
		$error("qcmbd_mem_block: width out of range");
	end

	// ---------------------------------------------------------------
	// storage and port state
	// ---------------------------------------------------------------
	logic [WIDTH-1:0] mem_reg [BLOCK_LINES];
	logic [NUM_PORTS*WIDTH-1:0] rdata_reg;
	logic [NUM_PORTS*WIDTH-1:0] rdata_next;
	logic [NUM_PORTS*2-1:0]     phase_reg;
	logic [NUM_PORTS*2-1:0]     phase_next;

	// read: straight to the sense phase, no decode phase; write: straight to the write phase
	always_comb
	begin
		rdata_next = rdata_reg;
		phase_next = phase_reg;
		for (int p = 0; p < NUM_PORTS; p++)
		begin
			if (wr_in[p])
				phase_next[p*2 +: 2] = QCMBD_PH_WRITE;
			else if (rd_in[p])
			begin
				phase_next[p*2 +: 2] = QCMBD_PH_SENSE;
				rdata_next[p*WIDTH +: WIDTH] = mem_reg[addr_in[p*6 +: 6]];
			end
			else
				phase_next[p*2 +: 2] = QCMBD_PH_IDLE;
		end
	end

	// register port state; writes land with the lower port winning last
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			rdata_reg <= '0;
			phase_reg <= '0;
		end
		else if (clk_en_in)
		begin
			rdata_reg <= rdata_next;
			phase_reg <= phase_next;
		end
	end

	// array write, no reset on the cells
	always_ff @(posedge sys_clk_in)
	begin
		if (clk_en_in && !rst_in)
		begin
			for (int p = NUM_PORTS-1; p >= 0; p--)
				if (wr_in[p])
					mem_reg[addr_in[p*6 +: 6]] <= wdata_in[p*WIDTH +: WIDTH];
		end
	end

	assign rdata_out = rdata_reg;
	assign phase_out = phase_reg;

endmodule

// File: src/qcmbd_instr_mem.sv
// shared instruction store built from multiplexed 64-line blocks
// assumes four fetch ports in one clock domain
`timescale 1ns/1ps
module qcmbd_instr_mem
	import qcmbd_pkg::*;
#(
	parameter int DEPTH = INSTR_DEPTH
)
(
	input  wire logic                         sys_clk_in,
	input  wire logic                         rst_in,
	input  wire logic                         clk_en_in,
	input  wire logic [NUM_PORTS*11-1:0]      fetch_addr_in,
	input  wire logic [NUM_PORTS-1:0]         fetch_in,
	input  wire logic                         load_in,
	input  wire logic [10:0]                  load_addr_in,
	input  wire logic [INSTR_W-1:0]           load_data_in,
	output logic      [NUM_PORTS*INSTR_W-1:0] instr_out
);

	localparam int NBLK = DEPTH / BLOCK_LINES;

	// the fetch address width only serves the full store
	if (DEPTH != INSTR_DEPTH)
	begin : g_bad_depth
		$error("qcmbd_instr_mem: depth must be 2048");
	end

	// ---------------------------------------------------------------
	// block array and output mux
	// ---------------------------------------------------------------
	logic [NUM_PORTS*INSTR_W-1:0] blk_rdata [NBLK];
	logic [NUM_PORTS*5-1:0]       sel_reg;
	logic [NUM_PORTS*5-1:0]       sel_next;
	logic [NUM_PORTS*6-1:0]       line_addr;

	// line address per port from the low six bits
	always_comb
	begin
		for (int p = 0; p < NUM_PORTS; p++)
			line_addr[p*6 +: 6] = fetch_addr_in[p*11 +: 6];
	end

	// remember which block each fetch read from
	always_comb
	begin
		sel_next = sel_reg;
		for (int p = 0; p < NUM_PORTS; p++)
			if (fetch_in[p])
				sel_next[p*5 +: 5] = fetch_addr_in[p*11+6 +: 5];
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
			sel_reg <= '0;
		else if (clk_en_in)
			sel_reg <= sel_next;
	end

	// 64-line blocks, larger store by multiplexing
	for (genvar b = 0; b < NBLK; b++)
	begin : g_blk
		logic [NUM_PORTS-1:0] rd_b;
		logic [NUM_PORTS-1:0] wr_b;
		logic [NUM_PORTS*6-1:0] a_b;
		always_comb
		begin
			for (int p = 0; p < NUM_PORTS; p++)
				rd_b[p] = fetch_in[p] && (fetch_addr_in[p*11+6 +: 5] == 5'(b));
			wr_b = {3'h0, load_in && (load_addr_in[10:6] == 5'(b))};
			a_b = wr_b[0] ? {line_addr[23:6], load_addr_in[5:0]} : line_addr;
		end
		qcmbd_mem_block #(.WIDTH(INSTR_W)) u_blk
		(
			.sys_clk_in (sys_clk_in),
			.rst_in     (rst_in),
			.clk_en_in  (clk_en_in),
			.rd_in      (rd_b),
			.wr_in      (wr_b),
			.addr_in    (a_b),
			.wdata_in   ({{(NUM_PORTS-1)*INSTR_W{1'b0}}, load_data_in}),
			.rdata_out  (blk_rdata[b]),
			.phase_out  ()
		);
	end

	// select each port's data from its block
	always_comb
	begin
		for (int p = 0; p < NUM_PORTS; p++)
			instr_out[p*INSTR_W +: INSTR_W] =
				blk_rdata[sel_reg[p*5 +: 5]][p*INSTR_W +: INSTR_W];
	end

endmodule

// File: src/qcmbd_top.sv
// decoder for i/o memory loads and stores and overflow branches,
// with the shared quad-ported instruction store
// assumes the cpu supplies register values and the overflow flag
// and wants a fetched word two edges after its fetch request
`timescale 1ns/1ps

// Function
// - opcodes 62 and 63 load from global i/o memory by register or immediate address.
// - opcodes 64 and 65 store a private register to global i/o memory.
// - opcodes 58 and 59 load from private i/o memory by register or immediate address.
// - opcodes 60 and 61 store a private register to private i/o memory.
// - opcodes 31 and 32 branch when overflow is set, immediate or register target.
// - opcode 34 and its immediate companion branch when overflow is clear.
// - a read precharges during address decode, then drives the word line and senses; the block model skips the decode phase and puts a read straight into sense.
// - a write decodes and drives the word line with bit lines forced, no precharge; the block model skips decode and goes straight to the write phase.
// - four independent ports may all read the same line in one cycle.
// - memory is built from 64-line blocks multiplexed together.
// - the opcode is the 7-bit field at the top of each 24-bit instruction.
// - the instruction store holds 2048 words and serves all four cpus.
module qcmbd_top
	import qcmbd_pkg::*;
(
	input  wire logic                         sys_clk_in,
	input  wire logic                         rst_in,
	input  wire logic                         clk_en_in,
	input  wire logic [NUM_PORTS-1:0]         fetch_in,
	input  wire logic [NUM_PORTS*11-1:0]      fetch_addr_in,
	input  wire logic                         load_in,
	input  wire logic [10:0]                  load_addr_in,
	input  wire logic [INSTR_W-1:0]           load_data_in,
	input  wire logic                         decode_valid_in,
	input  wire logic [INSTR_W-1:0]           instr_in,
	input  wire logic [31:0]                  src1_val_in,
	input  wire logic [31:0]                  src2_val_in,
	input  wire logic                         overflow_in,
	output logic      [NUM_PORTS*INSTR_W-1:0] instr_out,
	output logic                              gio_rd_out,
	output logic                              gio_wr_out,
	output logic                              pio_rd_out,
	output logic                              pio_wr_out,
	output logic      [31:0]                  io_addr_out,
	output logic      [31:0]                  io_wdata_out,
	output logic      [REG_SEL_W-1:0]         dest_sel_out,
	output logic                              dest_we_out,
	output logic                              branch_out,
	output logic      [31:0]                  branch_target_out
);

	// ---------------------------------------------------------------
	// instruction store
	// ---------------------------------------------------------------
	logic [NUM_PORTS*INSTR_W-1:0] im_data;

	qcmbd_instr_mem u_imem
	(
		.sys_clk_in    (sys_clk_in),
		.rst_in        (rst_in),
		.clk_en_in     (clk_en_in),
		.fetch_addr_in (fetch_addr_in),
		.fetch_in      (fetch_in),
		.load_in       (load_in),
		.load_addr_in  (load_addr_in),
		.load_data_in  (load_data_in),
		.instr_out     (im_data)
	);

	// ---------------------------------------------------------------
	// fetched instruction output
	// ---------------------------------------------------------------
	// port words as they leave the block mux
	logic [NUM_PORTS*INSTR_W-1:0] instr_reg;
	logic [NUM_PORTS*INSTR_W-1:0] instr_next;

	// follow the block mux; the mux alone would leave the pins combinational
	always_comb
	begin
		instr_next = im_data;
	end

	// one more stage, so a fetched word shows two edges after its request
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			instr_reg <= '0;
		end
		else if (clk_en_in)
		begin
			instr_reg <= instr_next;
		end
	end

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	// zero-extend the immediate field to a full address or target
	function automatic logic [31:0] imm_ext(input logic [INSTR_W-1:0] w);
		imm_ext = {20'h00000, w[IMM_MSB:IMM_LSB]};
	endfunction

	logic [OPC_W-1:0] opc;
	qcmbd_op_e        op;
	logic             use_imm;

	// opcode field at the top of the word
	assign opc = instr_in[OPC_MSB:OPC_LSB];

	// classify the opcode
	always_comb
	begin
		op      = QCMBD_OP_NONE;
		use_imm = 1'b0;
		unique case (opc)
			OPC_GLOBAL_IO_LOAD_REG_ADDR:   op = QCMBD_OP_LOAD_G;
			OPC_GLOBAL_IO_LOAD_IMM_ADDR:
			begin
				op = QCMBD_OP_LOAD_G;
				use_imm = 1'b1;
			end
			OPC_GLOBAL_IO_STORE_REG_ADDR:  op = QCMBD_OP_STORE_G;
			OPC_GLOBAL_IO_STORE_IMM_ADDR:
			begin
				op = QCMBD_OP_STORE_G;
				use_imm = 1'b1;
			end
			OPC_PRIVATE_IO_LOAD_REG_ADDR:  op = QCMBD_OP_LOAD_P;
			OPC_PRIVATE_IO_LOAD_IMM_ADDR:
			begin
				op = QCMBD_OP_LOAD_P;
				use_imm = 1'b1;
			end
			OPC_PRIVATE_IO_STORE_REG_ADDR: op = QCMBD_OP_STORE_P;
			OPC_PRIVATE_IO_STORE_IMM_ADDR:
			begin
				op = QCMBD_OP_STORE_P;
				use_imm = 1'b1;
			end
			OPC_BRANCH_ON_OVERFLOW_IMM:
			begin
				op = overflow_in ? QCMBD_OP_BRANCH : QCMBD_OP_NONE;
				use_imm = 1'b1;
			end
			OPC_BRANCH_ON_OVERFLOW_REG:
				op = overflow_in ? QCMBD_OP_BRANCH : QCMBD_OP_NONE;
			OPC_BRANCH_NO_OVERFLOW_IMM:
			begin
				op = overflow_in ? QCMBD_OP_NONE : QCMBD_OP_BRANCH;
				use_imm = 1'b1;
			end
			OPC_BRANCH_NO_OVERFLOW_REG:
				op = overflow_in ? QCMBD_OP_NONE : QCMBD_OP_BRANCH;
			default: op = QCMBD_OP_NONE;
		endcase
	end

	// ---------------------------------------------------------------
	// output state
	// ---------------------------------------------------------------
	logic                   gio_rd_reg;
	logic                   gio_rd_next;
	logic                   gio_wr_reg;
	logic                   gio_wr_next;
	logic                   pio_rd_reg;
	logic                   pio_rd_next;
	logic                   pio_wr_reg;
	logic                   pio_wr_next;
	logic [31:0]            addr_reg;
	logic [31:0]            addr_next;
	logic [31:0]            wdata_reg;
	logic [31:0]            wdata_next;
	logic [REG_SEL_W-1:0]   dsel_reg;
	logic [REG_SEL_W-1:0]   dsel_next;
	logic                   dwe_reg;
	logic                   dwe_next;
	logic                   br_reg;
	logic                   br_next;
	logic [31:0]            tgt_reg;
	logic [31:0]            tgt_next;
	logic [31:0]            ea;

	// effective address: immediate field or register source
	assign ea = use_imm ? imm_ext(instr_in) : src2_val_in;

	// strobes: one enabled cycle per decoded load, store or taken branch, low otherwise
	always_comb
	begin
		gio_rd_next = 1'b0;
		gio_wr_next = 1'b0;
		pio_rd_next = 1'b0;
		pio_wr_next = 1'b0;
		dwe_next    = 1'b0;
		br_next     = 1'b0;
		if (decode_valid_in)
		begin
			unique case (op)
				QCMBD_OP_LOAD_G:
				begin
					gio_rd_next = 1'b1;
					dwe_next    = 1'b1;
				end
				QCMBD_OP_LOAD_P:
				begin
					pio_rd_next = 1'b1;
					dwe_next    = 1'b1;
				end
				QCMBD_OP_STORE_G:
				begin
					gio_wr_next = 1'b1;
				end
				QCMBD_OP_STORE_P:
				begin
					pio_wr_next = 1'b1;
				end
				QCMBD_OP_BRANCH:
				begin
					br_next = 1'b1;
				end
				QCMBD_OP_NONE: ;
			endcase
		end
	end

	// fields hold their last value until an instruction replaces them
	always_comb
	begin
		addr_next  = addr_reg;
		wdata_next = wdata_reg;
		dsel_next  = dsel_reg;
		tgt_next   = tgt_reg;
		if (decode_valid_in)
		begin
			unique case (op)
				QCMBD_OP_LOAD_G, QCMBD_OP_LOAD_P:
				begin
					addr_next = ea;
					dsel_next = {1'b0, instr_in[DST_MSB:DST_LSB]};
				end
				QCMBD_OP_STORE_G, QCMBD_OP_STORE_P:
				begin
					addr_next  = ea;
					wdata_next = src1_val_in;
				end
				QCMBD_OP_BRANCH:
				begin
					tgt_next = use_imm ? imm_ext(instr_in) : src1_val_in;
				end
				QCMBD_OP_NONE: ;
			endcase
		end
	end

	// register the strobes
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			gio_rd_reg <= 1'b0;
			gio_wr_reg <= 1'b0;
			pio_rd_reg <= 1'b0;
			pio_wr_reg <= 1'b0;
			dwe_reg    <= 1'b0;
			br_reg     <= 1'b0;
		end
		else if (clk_en_in)
		begin
			gio_rd_reg <= gio_rd_next;
			gio_wr_reg <= gio_wr_next;
			pio_rd_reg <= pio_rd_next;
			pio_wr_reg <= pio_wr_next;
			dwe_reg    <= dwe_next;
			br_reg     <= br_next;
		end
	end

	// register the held fields
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			addr_reg  <= 32'h00000000;
			wdata_reg <= 32'h00000000;
			dsel_reg  <= '0;
			tgt_reg   <= 32'h00000000;
		end
		else if (clk_en_in)
		begin
			addr_reg  <= addr_next;
			wdata_reg <= wdata_next;
			dsel_reg  <= dsel_next;
			tgt_reg   <= tgt_next;
		end
	end

	// every output pin is fed by a register
	assign gio_rd_out        = gio_rd_reg;
	assign gio_wr_out        = gio_wr_reg;
	assign pio_rd_out        = pio_rd_reg;
	assign pio_wr_out        = pio_wr_reg;
	assign io_addr_out       = addr_reg;
	assign io_wdata_out      = wdata_reg;
	assign dest_sel_out      = dsel_reg;
	assign dest_we_out       = dwe_reg;
	assign branch_out        = br_reg;
	assign branch_target_out = tgt_reg;
	assign instr_out         = instr_reg;

endmodule

// File: testbench/qcmbd_properties.sv
// checker on the ports of qcmbd_top for decode strobes and reset
// assumes one clock, strobes one cycle after a taken instruction
`timescale 1ns/1ps
module qcmbd_properties
	import qcmbd_pkg::*;
(
	input wire logic                         sys_clk_in,
	input wire logic                         rst_in,
	input wire logic                         clk_en_in,
	input wire logic                         decode_valid_in,
	input wire logic [INSTR_W-1:0]           instr_in,
	input wire logic [31:0]                  src1_val_in,
	input wire logic [31:0]                  src2_val_in,
	input wire logic                         overflow_in,
	input wire logic                         gio_rd_out,
	input wire logic                         gio_wr_out,
	input wire logic                         pio_rd_out,
	input wire logic                         pio_wr_out,
	input wire logic [31:0]                  io_addr_out,
	input wire logic [31:0]                  io_wdata_out,
	input wire logic [REG_SEL_W-1:0]         dest_sel_out,
	input wire logic                         dest_we_out,
	input wire logic                         branch_out,
	input wire logic [31:0]                  branch_target_out
);
	// ---------------------------------------------------------------
	// decode helpers
	// ---------------------------------------------------------------
	logic        take;
	logic [6:0]  opc;
	logic [31:0] imm32;
	logic [5:0]  dst;
	logic        any_stb;
	assign take    = clk_en_in && decode_valid_in;
	assign opc     = instr_in[OPC_MSB:OPC_LSB];
	assign imm32   = {20'h0, instr_in[IMM_MSB:IMM_LSB]};
	assign dst     = {1'b0, instr_in[DST_MSB:DST_LSB]};
	assign any_stb = gio_rd_out | gio_wr_out | pio_rd_out | pio_wr_out | dest_we_out | branch_out;

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	a_gload_strobe: assert property (take && opc inside {7'h3e, 7'h3f} |=>
		gio_rd_out && dest_we_out && !gio_wr_out) else $error("global load strobe missing");
	a_gload_addr: assert property (take && opc == 7'h3e |=>
		io_addr_out == $past(src2_val_in)) else $error("global load address wrong");
	a_gstore_data: assert property (take && opc inside {7'h40, 7'h41} |=>
		gio_wr_out && !dest_we_out && io_wdata_out == $past(src1_val_in))
		else $error("global store wrong");
	a_pload_dest: assert property (take && opc inside {7'h3a, 7'h3b} |=>
		pio_rd_out && dest_we_out && dest_sel_out == $past(dst)) else $error("private load wrong");
	a_pstore_imm: assert property (take && opc == 7'h3d |=>
		pio_wr_out && io_addr_out == $past(imm32)) else $error("private store wrong");
	a_ovf_branch: assert property (take && opc == 7'h1f && overflow_in |=>
		branch_out && branch_target_out == $past(imm32)) else $error("overflow branch wrong");
	a_novf_branch: assert property (take && opc == 7'h22 && !overflow_in |=>
		branch_out && branch_target_out == $past(src1_val_in)) else $error("clear branch wrong");
	a_branch_refused: assert property (take && ((opc inside {7'h1f, 7'h20} && !overflow_in)
		|| (opc inside {7'h21, 7'h22} && overflow_in)) |=> !branch_out)
		else $error("branch taken on false condition");
	a_nop_quiet: assert property (take && !(opc inside {[7'h1f:7'h22], [7'h3a:7'h41]})
		|=> !any_stb) else $error("undefined opcode gave a strobe");
	a_reset_quiet: assert property (disable iff (1'b0) rst_in |=> !any_stb)
		else $error("strobe after reset edge");
endmodule

bind qcmbd_top qcmbd_properties u_props (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
	.clk_en_in(clk_en_in), .decode_valid_in(decode_valid_in), .instr_in(instr_in),
	.src1_val_in(src1_val_in), .src2_val_in(src2_val_in), .overflow_in(overflow_in),
	.gio_rd_out(gio_rd_out), .gio_wr_out(gio_wr_out), .pio_rd_out(pio_rd_out),
	.pio_wr_out(pio_wr_out), .io_addr_out(io_addr_out), .io_wdata_out(io_wdata_out),
	.dest_sel_out(dest_sel_out), .dest_we_out(dest_we_out), .branch_out(branch_out),
	.branch_target_out(branch_target_out));

// File: testbench/qcmbd_cpu_nodes.sv
// model of the four cpu nodes on the instruction store ports
// assumes start_in is changed by nonblocking assignment at the falling edge
`timescale 1ns/1ps
module qcmbd_cpu_nodes
	import qcmbd_pkg::*;
(
	input  wire logic                    sys_clk_in,
	input  wire logic                    start_in,
	input  wire logic                    wr_in,
	input  wire logic [10:0]             line_in,
	input  wire logic [INSTR_W-1:0]      word_in,
	output logic                         load_out,
	output logic      [10:0]             load_addr_out,
	output logic      [INSTR_W-1:0]      load_data_out,
	output logic      [NUM_PORTS-1:0]    fetch_out,
	output logic      [NUM_PORTS*11-1:0] fetch_addr_out
);
	initial
	begin
		load_out       = 1'b0;
		load_addr_out  = 11'h0;
		load_data_out  = '0;
		fetch_out      = '0;
		fetch_addr_out = '0;
	end

	// one write or a fetch by all four nodes of one line, then release
	always @(negedge sys_clk_in)
	begin
		load_out      <= start_in && wr_in;
		load_addr_out <= start_in ? line_in : ~load_addr_out; // released address toggles
		load_data_out <= start_in ? word_in : ~load_data_out;
		fetch_out     <= {NUM_PORTS{start_in && !wr_in}};
		fetch_addr_out <= start_in ? {NUM_PORTS{line_in}} : ~fetch_addr_out;
	end
endmodule

// File: testbench/qcmbd_top_tb.sv
// self-checking bench for qcmbd_top
// assumes outputs settle by the falling edge after the sampling edge
`timescale 1ns/1ps
module qcmbd_top_tb;
	import qcmbd_pkg::*;
	logic                         sys_clk = 1'b0;
	logic                         rst_in, clk_en_in, decode_valid_in, overflow_in;
	logic [INSTR_W-1:0]           instr_in, word, load_data;
	logic [31:0]                  src1, src2, io_addr, io_wdata, tgt;
	logic                         start, wr, load, g_rd, g_wr, p_rd, p_wr, d_we, br;
	logic [10:0]                  line, load_addr;
	logic [NUM_PORTS-1:0]         fetch;
	logic [NUM_PORTS*11-1:0]      fetch_addr;
	logic [NUM_PORTS*INSTR_W-1:0] instr_out;
	logic [5:0]                   dsel;
	int                           error_cnt = 0;
	int                           total_checks = 0;

	always #10 sys_clk = ~sys_clk;

	qcmbd_cpu_nodes u_cpus (.sys_clk_in(sys_clk), .start_in(start), .wr_in(wr), .line_in(line),
		.word_in(word), .load_out(load), .load_addr_out(load_addr), .load_data_out(load_data),
		.fetch_out(fetch), .fetch_addr_out(fetch_addr));
	qcmbd_top u_dut (.sys_clk_in(sys_clk), .rst_in(rst_in), .clk_en_in(clk_en_in),
		.fetch_in(fetch), .fetch_addr_in(fetch_addr), .load_in(load), .load_addr_in(load_addr),
		.load_data_in(load_data), .decode_valid_in(decode_valid_in), .instr_in(instr_in),
		.src1_val_in(src1), .src2_val_in(src2), .overflow_in(overflow_in),
		.instr_out(instr_out), .gio_rd_out(g_rd), .gio_wr_out(g_wr), .pio_rd_out(p_rd),
		.pio_wr_out(p_wr), .io_addr_out(io_addr), .io_wdata_out(io_wdata),
		.dest_sel_out(dsel), .dest_we_out(d_we), .branch_out(br), .branch_target_out(tgt));

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("checks=%0d errors=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// one store-port write or four-port fetch, checked on a fetch
	task automatic mem_op(input logic w, input logic [10:0] l, input logic [23:0] d);
		start <= 1'b1;
		wr    <= w;
		line  <= l;
		word  <= d;
		@(negedge sys_clk);
		start <= 1'b0;
		repeat (2) @(negedge sys_clk); // block register, then output register
		for (int p = 0; p < NUM_PORTS; p++)
			if (!w) chk({8'h0, instr_out[p*INSTR_W +: INSTR_W]}, {8'h0, d});
	endtask

	// issue one instruction at a falling edge, check the strobes one edge later
	task automatic send(input logic [6:0] opc, input logic ovf);
		logic [31:0] s1, s2, imm;
		logic        gl, gs, pl, ps, b, rf;
		s1 = 32'h8765_4300 + opc;
		s2 = 32'h00a5_5a00 + opc;
		imm = 32'h0000_0c35;
		instr_in = {opc, 12'hc35, 5'h15};
		src1 = s1;
		src2 = s2;
		overflow_in = ovf;
		decode_valid_in = 1'b1;
		@(negedge sys_clk);
		gl = opc inside {7'h3e, 7'h3f};
		gs = opc inside {7'h40, 7'h41};
		pl = opc inside {7'h3a, 7'h3b};
		ps = opc inside {7'h3c, 7'h3d};
		b  = (opc inside {7'h1f, 7'h20} && ovf) || (opc inside {7'h21, 7'h22} && !ovf);
		rf = opc inside {7'h3e, 7'h40, 7'h3a, 7'h3c, 7'h20, 7'h22};
		chk({26'h0, g_rd, g_wr, p_rd, p_wr, d_we, br}, {26'h0, gl, gs, pl, ps, gl | pl, b});
		if (gl | gs | pl | ps) chk(io_addr, rf ? s2 : imm);
		if (gs | ps) chk(io_wdata, s1);
		if (gl | pl) chk({26'h0, dsel}, 32'h15);
		if (b) chk(tgt, rf ? s1 : imm);
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		chk({26'h0, g_rd, g_wr, p_rd, p_wr, d_we, br}, 32'h0);
		chk(io_addr, 32'h0);
	endtask

	task automatic t_mem();
		logic [10:0] ln [4] = '{11'h000, 11'h03f, 11'h040, 11'h7ff};
		foreach (ln[i]) mem_op(1'b1, ln[i], 24'ha5_0000 ^ {13'h0, ln[i]});
		foreach (ln[i]) mem_op(1'b0, ln[i], 24'ha5_0000 ^ {13'h0, ln[i]});
	endtask

	task automatic t_io();
		send(7'h3e, 1'b0); send(7'h3f, 1'b1);
		send(7'h40, 1'b0); send(7'h41, 1'b0);
		send(7'h3a, 1'b0); send(7'h3b, 1'b0);
		send(7'h3c, 1'b0); send(7'h3d, 1'b1);
		decode_valid_in = 1'b0;
	endtask

	task automatic t_branch();
		for (int v = 0; v < 2; v++)
		begin
			send(7'h1f, v[0]); send(7'h20, v[0]);
			send(7'h21, v[0]); send(7'h22, v[0]);
		end
		decode_valid_in = 1'b0;
	endtask

	task automatic t_nop();
		send(7'h40, 1'b0); send(7'h00, 1'b1); send(7'h1e, 1'b1);
		send(7'h23, 1'b0); send(7'h42, 1'b0); send(7'h7f, 1'b1);
		decode_valid_in = 1'b0;
	endtask

	// a low clock enable freezes the decoder: the store strobe stands
	task automatic t_hold();
		send(7'h41, 1'b0);
		clk_en_in = 1'b0;
		instr_in = {7'h3e, 12'h0a0, 5'h03};
		repeat (2) @(negedge sys_clk);
		chk({26'h0, g_rd, g_wr, p_rd, p_wr, d_we, br}, 32'h10);
		chk(io_addr, 32'h0000_0c35);
		clk_en_in = 1'b1;
		decode_valid_in = 1'b0;
		@(negedge sys_clk);
		chk({26'h0, g_rd, g_wr, p_rd, p_wr, d_we, br}, 32'h0);
	endtask

	// ---------------------------------------------------------------
	// main sequence and watchdog
	// ---------------------------------------------------------------
	initial
	begin
		rst_in = 1'b1;
		clk_en_in = 1'b1;
		decode_valid_in = 1'b0;
		instr_in = '0;
		src1 = '0;
		src2 = '0;
		overflow_in = 1'b0;
		start = 1'b0;
		wr = 1'b0;
		line = '0;
		word = '0;
		repeat (4) @(negedge sys_clk);
		rst_in = 1'b0;
		t_reset();
		t_mem();
		t_io();
		t_branch();
		t_nop();
		t_hold();
		wrap_up();
	end

	initial
	begin
		#100000;
		error_cnt++;
		wrap_up();
	end
endmodule
